// file: src/rtu_framer_regs.vh
// Purpose: Shared constants of the RTU slave framer
// Assumes: One 100 MHz core clock
// Notes:   Definitions only
`ifndef RTU_FRAMER_REGS_VH
`define RTU_FRAMER_REGS_VH

// ==========================================================================
// Clock and character timing
`define CLK_HZ          100000000
`define BAUD_DEFAULT    9600
`define CHAR_BITS_DEF   11
// Gap lengths in tenths of a character time
`define GAP_ABORT_X10   15
`define GAP_END_X10     35

// ==========================================================================
// Checksum
`define CRC_INIT        16'hffff
`define CRC_POLY        16'ha001

// ==========================================================================
// Addresses and function codes
`define ADDR_BCAST      8'h00
`define ADDR_MIN        8'h01
`define ADDR_MAX        8'hf7
`define FUNC_READ       8'h03
`define FUNC_WRITE      8'h06
`define FUNC_FAULT_FLAG 8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_VALUE   8'h03
`define MAX_WORDS       5'h10
`define REQ_LEN         4'h8
`define REQ_TOO_LONG    4'h9

// ==========================================================================
// Reply kinds
`define REP_READ        2'h0
`define REP_WRITE       2'h1
`define REP_FAULT       2'h2
// Reply lengths without data words
`define LEN_READ_BASE   6'h05
`define LEN_WRITE       6'h08
`define LEN_FAULT       6'h05

// ==========================================================================
// Controller states
`define ST_LISTEN       2'h0
`define ST_ACCESS       2'h1
`define ST_SEND         2'h2
`define ST_DRAIN        2'h3

`endif

// file: src/rtu_slave_framer.v
// Purpose: RTU slave framing, request decode, reply build with checksum
// Assumes: Byte UART on the same clock; driver enable controls the bus
// Notes:   Only read words and write one word are served
`timescale 1ns/1ps
`include "rtu_framer_regs.vh"

module rtu_slave_framer #(
  parameter integer BAUD      = `BAUD_DEFAULT,
  parameter integer CHAR_BITS = `CHAR_BITS_DEF,
  parameter integer CHAR_CYC  = (`CLK_HZ / BAUD) * CHAR_BITS,
  parameter integer T15_CYC   = (CHAR_CYC * `GAP_ABORT_X10) / 10,
  parameter integer T35_CYC   = (CHAR_CYC * `GAP_END_X10 + 9) / 10,
  parameter integer GAP_W     = 22
) (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire [7:0]  i_own_addr,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  input  wire        i_tx_ready,
  input  wire        i_tx_idle,
  input  wire        i_acc_ack,
  input  wire [15:0] i_acc_rdata,
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_en,
  output reg         o_acc_req,
  output reg         o_acc_write,
  output reg  [15:0] o_acc_addr,
  output reg  [15:0] o_acc_wdata,
  output reg         o_frame_ok,
  output reg         o_crc_err,
  output reg         o_abort,
  output reg         o_busy
);

  // ========================================================================
  // Timing limits at counter width
  localparam [GAP_W-1:0] T15 = T15_CYC[GAP_W-1:0];
  localparam [GAP_W-1:0] T35 = T35_CYC[GAP_W-1:0];
  localparam [GAP_W-1:0] GAP_MAX = {GAP_W{1'b1}};

  // ========================================================================
  // Checksum step
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  b;
    integer      i;
    reg   [15:0] r;
    begin
      r = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0]) begin
          r = (r >> 1) ^ `CRC_POLY;
        end else begin
          r = r >> 1;
        end
      end
      crc_byte = r;
    end
  endfunction

  // ========================================================================
  // State
  reg [1:0]       state;
  reg [GAP_W-1:0] gap;
  reg             synced;
  reg             in_frame;
  reg [3:0]       rx_cnt;
  reg [7:0]       rx_buf [0:7];
  reg [15:0]      rx_crc;
  reg [15:0]      crc_body;
  reg             is_bcast;
  reg [1:0]       rep_kind;
  reg [7:0]       exc_code;
  reg [4:0]       n_words;
  reg [4:0]       word_idx;
  reg [5:0]       tx_idx;
  reg [5:0]       tx_len;
  reg [15:0]      tx_crc;

  // ========================================================================
  // Request decode of the held frame
  wire [15:0] rx_start  = {rx_buf[2], rx_buf[3]};
  wire [15:0] rx_value  = {rx_buf[4], rx_buf[5]};
  wire [15:0] rx_sum    = {rx_buf[7], rx_buf[6]};
  wire        own_ok    = (i_own_addr >= `ADDR_MIN) && (i_own_addr <= `ADDR_MAX);
  wire        addr_me   = own_ok && (rx_buf[0] == i_own_addr);
  wire        addr_all  = (rx_buf[0] == `ADDR_BCAST);
  wire        sum_ok    = (rx_cnt == `REQ_LEN) && (crc_body == rx_sum);
  wire        cnt_ok    = (rx_value != 16'h0000) &&
                          (rx_value <= {11'h000, `MAX_WORDS});
  wire        frame_end = in_frame && (gap >= T35);
  wire        rx_take   = i_rx_valid && (state == `ST_LISTEN);
  wire        tx_fire   = o_tx_valid && i_tx_ready;

  // ========================================================================
  // Read word store; one slot per word keeps the write side free of a wide mux
  wire         word_wr  = (state == `ST_ACCESS) && i_acc_ack && !o_acc_write;
  wire [15:0]  word_hit = 16'h0001 << word_idx[3:0];
  wire [255:0] word_flat;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_word
      reg [15:0] slot;
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          slot <= 16'h0000;
        end else if (word_wr && word_hit[gi]) begin
          slot <= i_acc_rdata;
        end
      end
      assign word_flat[gi*16 +: 16] = slot;
    end
  endgenerate

  // ========================================================================
  // Next reply byte, chosen for index tx_idx + 1
  reg [5:0]  next_idx;
  reg [5:0]  word_off;
  reg [15:0] next_tx_crc;
  reg [15:0] word_sel;
  reg [7:0]  next_byte;

  always @* begin
    next_idx    = tx_idx + 6'h01;
    word_off    = next_idx - 6'h03;
    next_tx_crc = crc_byte(tx_crc, o_tx_data);
    word_sel    = word_flat[{word_off[4:1], 4'h0} +: 16];
    next_byte   = 8'h00;
    if (next_idx == tx_len - 6'h02) begin
      next_byte = next_tx_crc[7:0];
    end else if (next_idx == tx_len - 6'h01) begin
      next_byte = tx_crc[15:8];
    end else if (next_idx == 6'h01) begin
      next_byte = (rep_kind == `REP_FAULT) ? (rx_buf[1] | `FUNC_FAULT_FLAG)
                                           : rx_buf[1];
    end else if (rep_kind == `REP_FAULT) begin
      next_byte = exc_code;
    end else if (rep_kind == `REP_WRITE) begin
      next_byte = rx_buf[next_idx[2:0]];
    end else if (next_idx == 6'h02) begin
      next_byte = {2'b00, n_words, 1'b0};
    end else begin
      next_byte = word_off[0] ? word_sel[7:0] : word_sel[15:8];
    end
  end

  // ========================================================================
  // Receive, decode, access and send
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state       <= `ST_LISTEN;
      gap         <= {GAP_W{1'b0}};
      synced      <= 1'b0;
      in_frame    <= 1'b0;
      rx_cnt      <= 4'h0;
      rx_crc      <= `CRC_INIT;
      crc_body    <= `CRC_INIT;
      is_bcast    <= 1'b0;
      rep_kind    <= `REP_READ;
      exc_code    <= 8'h00;
      n_words     <= 5'h00;
      word_idx    <= 5'h00;
      tx_idx      <= 6'h00;
      tx_len      <= 6'h00;
      tx_crc      <= `CRC_INIT;
      o_tx_valid  <= 1'b0;
      o_tx_data   <= 8'h00;
      o_tx_en     <= 1'b0;
      o_acc_req   <= 1'b0;
      o_acc_write <= 1'b0;
      o_acc_addr  <= 16'h0000;
      o_acc_wdata <= 16'h0000;
      o_frame_ok  <= 1'b0;
      o_crc_err   <= 1'b0;
      o_abort     <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      o_frame_ok <= 1'b0;
      o_crc_err  <= 1'b0;
      o_abort    <= 1'b0;
      // Gap timer restarts on every byte taken while listening and saturates
      if (rx_take) begin
        gap <= {GAP_W{1'b0}};
      end else if (gap != GAP_MAX) begin
        gap <= gap + {{(GAP_W-1){1'b0}}, 1'b1};
      end
      if (gap >= T35) begin
        synced <= 1'b1;
      end
      case (state)
        `ST_LISTEN: begin
          if (rx_take) begin
            // Bytes before the first full idle are line noise
            if (!synced) begin
              in_frame <= 1'b0;
            end else if (!in_frame || gap > T15) begin
              o_abort   <= in_frame;
              in_frame  <= 1'b1;
              rx_buf[0] <= i_rx_data;
              rx_cnt    <= 4'h1;
              rx_crc    <= crc_byte(`CRC_INIT, i_rx_data);
            end else begin
              // Short gaps keep extending; overlength fails the check
              if (rx_cnt < `REQ_LEN) begin
                rx_buf[rx_cnt[2:0]] <= i_rx_data;
              end
              if (rx_cnt < `REQ_TOO_LONG) begin
                rx_cnt <= rx_cnt + 4'h1;
              end
              if (rx_cnt == 4'h5) begin
                crc_body <= crc_byte(rx_crc, i_rx_data);
              end
              rx_crc <= crc_byte(rx_crc, i_rx_data);
            end
          end else if (frame_end) begin
            in_frame <= 1'b0;
            is_bcast <= addr_all;
            exc_code <= 8'h00;
            if (!sum_ok) begin
              o_crc_err <= 1'b1;
            end else if (addr_me || addr_all) begin
              o_frame_ok  <= 1'b1;
              o_busy      <= 1'b1;
              o_acc_addr  <= rx_start;
              o_acc_wdata <= rx_value;
              word_idx    <= 5'h00;
              n_words     <= rx_value[4:0];
              if (rx_buf[1] == `FUNC_WRITE) begin
                o_acc_req   <= 1'b1;
                o_acc_write <= 1'b1;
                rep_kind    <= `REP_WRITE;
                state       <= `ST_ACCESS;
              end else if (rx_buf[1] == `FUNC_READ && cnt_ok && addr_me) begin
                o_acc_req   <= 1'b1;
                o_acc_write <= 1'b0;
                rep_kind    <= `REP_READ;
                state       <= `ST_ACCESS;
              end else if (addr_me) begin
                // Line has been idle 3.5 characters already
                rep_kind    <= `REP_FAULT;
                exc_code    <= (rx_buf[1] == `FUNC_READ) ? `EXC_BAD_VALUE
                                                          : `EXC_BAD_FUNC;
                tx_len      <= `LEN_FAULT;
                tx_idx      <= 6'h00;
                tx_crc      <= `CRC_INIT;
                o_tx_data   <= rx_buf[0];
                o_tx_valid  <= 1'b1;
                o_tx_en     <= 1'b1;
                state       <= `ST_SEND;
              end else begin
                // Broadcast of anything but a write has nothing to carry out
                o_busy <= 1'b0;
              end
            end
          end
        end
        `ST_ACCESS: begin
          if (i_acc_ack) begin
            if (o_acc_write) begin
              o_acc_req <= 1'b0;
            end else begin
              word_idx                <= word_idx + 5'h01;
              o_acc_addr              <= o_acc_addr + 16'h0001;
              if (word_idx + 5'h01 == n_words) begin
                o_acc_req <= 1'b0;
              end
            end
            if (o_acc_write || word_idx + 5'h01 == n_words) begin
              if (is_bcast) begin
                o_busy <= 1'b0;
                state  <= `ST_LISTEN;
              end else begin
                tx_len     <= o_acc_write ? `LEN_WRITE
                                          : `LEN_READ_BASE + {n_words, 1'b0};
                tx_idx     <= 6'h00;
                tx_crc     <= `CRC_INIT;
                o_tx_data  <= rx_buf[0];
                o_tx_valid <= 1'b1;
                o_tx_en    <= 1'b1;
                state      <= `ST_SEND;
              end
            end
          end
        end
        `ST_SEND: begin
          if (tx_fire) begin
            if (tx_idx < tx_len - 6'h02) begin
              tx_crc <= next_tx_crc;
            end
            if (tx_idx == tx_len - 6'h01) begin
              o_tx_valid <= 1'b0;
              state      <= `ST_DRAIN;
            end else begin
              // Next byte ready at once, so no gap opens
              tx_idx    <= next_idx;
              o_tx_data <= next_byte;
            end
          end
        end
        `ST_DRAIN: begin
          // Hold the driver until the last stop bit leaves
          if (i_tx_idle) begin
            o_tx_en  <= 1'b0;
            o_busy   <= 1'b0;
            in_frame <= 1'b0;
            gap      <= {GAP_W{1'b0}};
            state    <= `ST_LISTEN;
          end
        end
        default: begin
          state <= `ST_LISTEN;
        end
      endcase
    end
  end

endmodule // rtu_slave_framer

// file: tb/rtu_framer_sva.sv
// Purpose: Concurrent checks on the RTU slave framer ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Gap counter mirrors the receive idle timer
`timescale 1ns/1ps
module rtu_framer_sva #(
  parameter integer T15_CYC = 30,
  parameter integer T35_CYC = 70
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_rx_valid,
  input wire logic        i_tx_ready,
  input wire logic        i_tx_idle,
  input wire logic        i_acc_ack,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        o_tx_en,
  input wire logic        o_acc_req,
  input wire logic        o_acc_write,
  input wire logic [15:0] o_acc_addr,
  input wire logic        o_frame_ok,
  input wire logic        o_crc_err,
  input wire logic        o_abort,
  input wire logic        o_busy
);
  int gap = 0;
  int last_gap = 0;
  // ==========================================================================
  // Idle timer; saturates so a long quiet line never wraps it
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_rx_valid) gap <= 0;
    else if (gap < 100000) gap <= gap + 1;
    if (i_rx_valid) last_gap <= gap;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Properties
  a_send_needs_en: assert property (o_tx_valid |-> o_tx_en)
    else $error("byte offered while driver off");
  a_en_release: assert property (o_tx_en && !o_tx_valid && i_tx_idle |-> ##[1:2] !o_tx_en)
    else $error("driver held after line idle");
  a_en_holds: assert property (o_tx_en && (o_tx_valid || !i_tx_idle) |=> o_tx_en)
    else $error("driver released while line busy");
  a_busy_serving: assert property (o_acc_req || o_tx_en |-> o_busy)
    else $error("serving while not busy");
  a_idle_before_send: assert property ($rose(o_tx_en) |-> gap >= T35_CYC)
    else $error("reply started too soon");
  a_end_after_quiet: assert property (o_frame_ok |-> gap >= T35_CYC && gap <= T35_CYC + 2)
    else $error("frame end at wrong time");
  a_err_after_quiet: assert property (o_crc_err |-> gap >= T35_CYC && gap <= T35_CYC + 2)
    else $error("error pulse at wrong time");
  a_abort_long_gap: assert property (o_abort |-> $past(i_rx_valid) && last_gap > T15_CYC)
    else $error("flush without long gap");
  a_short_gap_appends: assert property (i_rx_valid && gap < T15_CYC |=> !o_abort)
    else $error("flush on short gap");
  a_byte_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("offered byte dropped or changed");
  a_req_until_ack: assert property (o_acc_req && !i_acc_ack |=> o_acc_req && $stable(o_acc_addr))
    else $error("access request not held");
  a_read_steps: assert property (o_acc_req && !o_acc_write && i_acc_ack
    |=> !o_acc_req || o_acc_addr == $past(o_acc_addr) + 16'h0001)
    else $error("read address did not step");
  c_frame: cover property (o_frame_ok);
  c_abort: cover property (o_abort);
  c_error: cover property (o_crc_err);
  c_read: cover property (o_acc_req && i_acc_ack && !o_acc_write);
endmodule // rtu_framer_sva

bind rtu_slave_framer rtu_framer_sva #(.T15_CYC(T15_CYC), .T35_CYC(T35_CYC)) chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
  .i_tx_ready(i_tx_ready), .i_tx_idle(i_tx_idle), .i_acc_ack(i_acc_ack),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_en(o_tx_en),
  .o_acc_req(o_acc_req), .o_acc_write(o_acc_write), .o_acc_addr(o_acc_addr),
  .o_frame_ok(o_frame_ok), .o_crc_err(o_crc_err), .o_abort(o_abort), .o_busy(o_busy));

// file: tb/rtu_host.sv
// Purpose: Host model: sends request bytes, takes reply bytes
// Assumes: Byte-level link; a character lasts CHAR_CYC clocks
// Notes:   Send side stalls at random so held bytes get exercised
`timescale 1ns/1ps
module rtu_host #(
  parameter integer CHAR_CYC = 20
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_tx_valid,
  input  wire logic  i_tx_en,
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic       o_tx_ready,
  output logic       o_tx_idle
);
  integer seed = 32'hf8782a0e;
  int shift = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
  end
  // ==========================================================================
  // Checksum over data bytes only
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // ==========================================================================
  // Receive side of the link; data line shows junk when released
  task automatic put_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge i_core_clk);
    wait (!i_tx_en);
    o_rx_valid <= 1'b1;
    o_rx_data <= b;
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~b;
  endtask
  // Frame: first byte after the given quiet, rest back to back
  task automatic send_frame(input logic [7:0] q[$], input int first);
    foreach (q[i]) put_byte(q[i], i ? CHAR_CYC - 1 : first);
  endtask
  // ==========================================================================
  // UART send side: shifter busy one character after each accept
  always @(posedge i_core_clk) begin
    o_tx_ready <= 1'($random(seed));
    if (i_tx_valid && o_tx_ready) shift <= CHAR_CYC;
    else if (shift > 0) shift <= shift - 1;
    o_tx_idle <= !(i_tx_valid && o_tx_ready) && shift <= 1;
  end
endmodule // rtu_host

// file: tb/testbench.sv
// Purpose: Self-checking bench for the RTU slave framer
// Assumes: Host model drives the link; bench plays the application
// Notes:   One queue holds every expected output event in order
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk;
  logic        i_rst;
  logic [7:0]  i_own_addr;
  logic        i_rx_valid;
  logic [7:0]  i_rx_data;
  logic        i_tx_ready;
  logic        i_tx_idle;
  logic        i_acc_ack;
  logic [15:0] i_acc_rdata;
  logic        o_tx_valid, o_tx_en, o_acc_req, o_acc_write;
  logic        o_frame_ok, o_crc_err, o_abort, o_busy;
  logic [7:0]  o_tx_data;
  logic [15:0] o_acc_addr, o_acc_wdata;
  logic [7:0]  foreign;
  logic [39:0] exp_q[$];
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  integer      seed = 32'hf8782a0e;

  rtu_slave_framer #(.CHAR_CYC(20), .T15_CYC(30), .T35_CYC(70)) DUT (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_own_addr(i_own_addr),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
    .i_tx_idle(i_tx_idle), .i_acc_ack(i_acc_ack), .i_acc_rdata(i_acc_rdata),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_en(o_tx_en),
    .o_acc_req(o_acc_req), .o_acc_write(o_acc_write), .o_acc_addr(o_acc_addr),
    .o_acc_wdata(o_acc_wdata), .o_frame_ok(o_frame_ok), .o_crc_err(o_crc_err),
    .o_abort(o_abort), .o_busy(o_busy));
  rtu_host #(.CHAR_CYC(20)) host (
    .i_core_clk(i_core_clk), .i_tx_valid(o_tx_valid), .i_tx_en(o_tx_en),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready),
    .o_tx_idle(i_tx_idle));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic give_verdict;
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic note(input logic [39:0] got);
    logic [39:0] want;
    want = 40'h00_0000_0000;
    if (exp_q.size() != 0) want = exp_q[0];
    checks++;
    if (exp_q.size() == 0 || got !== want) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, want, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask
  // ==========================================================================
  // Application side and event watcher; a hang ends as a failure
  always @(posedge i_core_clk) begin
    i_acc_ack <= o_acc_req && !i_acc_ack;
    i_acc_rdata <= o_acc_addr ^ 16'h5a5a;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
    if (!i_rst) begin
      if (o_abort) note(40'h06_0000_0000);
      if (o_frame_ok) note(40'h02_0000_0000);
      if (o_crc_err) note(40'h03_0000_0000);
      if (o_acc_req && i_acc_ack) note({7'h02, o_acc_write, o_acc_addr, o_acc_wdata});
      if (o_tx_valid && i_tx_ready) note({8'h01, 24'h0, o_tx_data});
    end
  end
  // ==========================================================================
  // One request: note expected events, send it, wait until served
  task automatic req(input logic [7:0] a, f, input logic [15:0] s, v,
                     input logic [7:0] bad = 8'h00, input bit ext = 0, input bit ab = 0);
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [15:0] c;
    logic [15:0] w;
    q = '{a, f, s[15:8], s[7:0], v[15:8], v[7:0]};
    c = host.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ bad);
    if (ext) q.push_back(8'h00);
    if (ab) exp_q.push_back(40'h06_0000_0000);
    if (bad != 8'h00 || ext) exp_q.push_back(40'h03_0000_0000);
    else if (a == i_own_addr || a == 8'h00) begin
      exp_q.push_back(40'h02_0000_0000);
      if (f == 8'h06) begin
        exp_q.push_back({8'h05, s, v});
        r = q[0:5];
      end else if (f == 8'h03 && v >= 16'h0001 && v <= 16'h0010 && a != 8'h00) begin
        r = '{a, f, 8'(2 * v)};
        for (int i = 0; i < v; i++) begin
          exp_q.push_back({8'h04, s + 16'(i), v});
          w = (s + 16'(i)) ^ 16'h5a5a;
          r.push_back(w[15:8]);
          r.push_back(w[7:0]);
        end
      end else r = '{a, f | 8'h80, (f == 8'h03) ? 8'h03 : 8'h01};
      c = host.crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
      if (a == i_own_addr) foreach (r[i]) exp_q.push_back({8'h01, 24'h0, r[i]});
    end
    for (int i = 0; i < 3 && ab; i++) host.put_byte(8'h11, i ? 19 : 75);
    host.send_frame(q, ab ? 45 : 75);
    for (int k = 0; k < 5000 && (exp_q.size() != 0 || o_busy); k++) @(posedge i_core_clk);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    @(posedge i_core_clk);
    i_own_addr <= 8'h01 + 8'($unsigned($random(seed)) % 247);
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    foreign = (i_own_addr == 8'hf7) ? 8'h01 : i_own_addr + 8'h01;
    req(i_own_addr, 8'h03, 16'h0107, 16'h0002);
    req(i_own_addr, 8'h03, 16'hfff8, 16'h0010);
    req(i_own_addr, 8'h03, 16'h0000, 16'h0011);
    req(i_own_addr, 8'h03, 16'h0000, 16'h0000);
    req(i_own_addr, 8'h05, 16'h1000, 16'h0001);
    for (int i = 0; i < 3; i++) req(i_own_addr, 8'h06, 16'($random(seed)), 16'($random(seed)));
    req(8'h00, 8'h06, 16'h2000, 16'h0001);
    req(8'h00, 8'h03, 16'h0100, 16'h0002);
    req(foreign, 8'h06, 16'h2000, 16'h0002);
    req(i_own_addr, 8'h06, 16'h2000, 16'h0003, 8'h5a);
    req(i_own_addr, 8'h06, 16'h2000, 16'h0004, 8'h00, 1);
    req(i_own_addr, 8'h03, 16'h1000, 16'h0001, 8'h00, 0, 1);
    repeat (100) @(posedge i_core_clk);
    give_verdict();
  end
endmodule // testbench
